/* File: include/sb_consts.svh */
// Timing and layout constants for the dual-issue scoreboard.
// Assumes inclusion by bare name from the scoreboard sources.
`ifndef SB_CONSTS_SVH
`define SB_CONSTS_SVH

// Producer latencies in issue cycles, base use and store-data use.
`define SB_LAT_LOAD     6'd3
`define SB_LAT_ADD      6'd1
`define SB_LAT_ADD_SD   6'd0
`define SB_LAT_SHIFT    6'd2
`define SB_LAT_SHIFT_SD 6'd0
`define SB_LAT_CMP      6'd2
`define SB_LAT_FOP      6'd6
`define SB_LAT_OTHER    6'd3

// Multiplier and divider: dependent latency and occupancy.
`define SB_LAT_MUL      21
`define SB_OCC_MUL      19
`define SB_LAT_DIV      34
`define SB_OCC_DIV      30

// Forbidden slots before completion and the load gap after a
// conditional store.
`define SB_MUL_GAP      6'd3
`define SB_DIV_GAP_A    6'd5
`define SB_DIV_GAP_B    6'd6
`define SB_SC_GAP       2'd2

// Register file layout: bit 5 selects the float file.
`define SB_ZERO_REG     5'h1f
`define SB_NREG         64

`endif

/* File: include/sb_pkg.sv */
// Types shared by the scoreboard modules.
// Assumes no other package; constants live in sb_consts.svh.
`default_nettype none

package sb_pkg;

    // Instruction classes as decoded by fetch.
    typedef enum logic [4:0] {
        C_NONE              = 5'b00000,
        C_LOAD_INT          = 5'b00001,
        C_LOAD_FP           = 5'b00010,
        C_WRITE_INT         = 5'b00011,
        C_WRITE_FP          = 5'b00100,
        C_STORE_COND        = 5'b00101,
        C_PREFILL           = 5'b00110,
        C_CYCLE_CTR         = 5'b00111,
        C_FLAG_RDSET        = 5'b01000,
        C_MEM_BARRIER       = 5'b01001,
        C_TRAP_BARRIER      = 5'b01010,
        C_PROC_REG_MOVE     = 5'b01011,
        C_EXC_RETURN        = 5'b01100,
        C_JUMP_SUB          = 5'b01101,
        C_BRANCH_SUB        = 5'b01110,
        C_UNCOND_JUMP       = 5'b01111,
        C_INT_COND_BRANCH   = 5'b10000,
        C_FLOAT_COND_BRANCH = 5'b10001,
        C_INT_ADD_LOGIC     = 5'b10010,
        C_SHIFT             = 5'b10011,
        C_INT_COMPARE       = 5'b10100,
        C_INT_COND_MOVE     = 5'b10101,
        C_INT_MULTIPLY      = 5'b10110,
        C_FLOAT_OPERATE     = 5'b10111,
        C_FLOAT_DIVIDE      = 5'b11000,
        C_HW_SPECIAL        = 5'b11001,
        C_PRIV_CALL         = 5'b11010
    } sb_cls_t;

    // One candidate or issued instruction.
    typedef struct packed {
        logic       vld;
        sb_cls_t    cls;
        logic [5:0] dst;
        logic [5:0] sa;
        logic [5:0] sb;
        logic       sa_use;
        logic       sb_use;
    } sb_ins_t;

    // State of one long-latency unit tracker.
    typedef struct packed {
        logic [5:0] remain;
    } sb_unit_st_t;

    // State of the issue controller.
    typedef struct packed {
        logic [63:0][5:0] cnt;
        logic [63:0][5:0] dcnt;
        logic [63:0]      hold;
        sb_ins_t [1:0]    slot;
        logic             quad;
        logic             ready;
        sb_ins_t          out0;
        sb_ins_t          out1;
        logic             mb_pend;
        logic             jmp_prev;
        logic [1:0]       sc_cnt;
        logic [1:0]       ack_sync;
    } sb_st_t;

endpackage

`default_nettype wire

/* File: verilog/sb_unit_track.sv */
// Busy and completion tracker for one long-latency unit.
// Assumes start_i only when busy_o is low; one clock, async reset.
`include "sb_consts.svh"
`default_nettype none

module sb_unit_track #(
    parameter int LAT = `SB_LAT_MUL,
    parameter int OCC = `SB_OCC_MUL
) (
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic       start_i,
    output logic            busy_o,
    output logic [5:0]      remain_o
);
    import sb_pkg::*;

    sb_unit_st_t q;
    sb_unit_st_t d;

    // Load the completion distance on start, then count down.
    always_comb begin
        d = q;
        if (start_i) begin
            d.remain = 6'(LAT - 1);
        end else if (q.remain != 6'h00) begin
            d.remain = q.remain - 6'h01;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Occupied until only the tail beyond occupancy is left.
    assign busy_o   = q.remain > 6'(LAT - OCC);
    assign remain_o = q.remain;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    chk_busy_span: assert property (
        start_i |=> (busy_o && remain_o == 6'(LAT - 1)) ##1 busy_o[*7])
        else $error("unit not busy after start");

endmodule

`default_nettype wire

/* File: verilog/sb_issue_ctl.sv */
// In-order dual-issue control with register scoreboard.
// Assumes fetch decodes classes, registers and same-quadword pairing,
// and the address unit reports misses on this clock.
// Function
// - Consumer issues no earlier than the producer latency after it.
// - Add/logic result as store data has zero latency; may pair.
// - Loads assume cache hit; miss holds until one cycle before write.
// - Store base and store data sources use separate latencies.
// - Dependent multiply waits full latency, independent waits occupancy.
// - Dependent divide waits full latency, independent waits occupancy.
// - Later writer of a slow producer's destination stalls for order.
// - Issue only with sources ready and destination writes ordered.
// - Barrier blocks memory-type instructions until acknowledged outside.
// - Multiply is held while the multiplier is busy.
// - Simple integer ops blocked three cycles before multiply ends.
// - No conditional branch the cycle after a computed jump.
// - Trap barrier issues only first or alone.
// - No load in the two cycles after a conditional store.
// - Memory-type instructions held while the address unit is busy.
// - Divide is held while the divider is busy.
// - No float operate five or six cycles before divide ends.
// - Pairs need one quadword, no dependency, allowed class pair.
// - At most one memory-group instruction per cycle.
// - At most one control-transfer instruction per cycle.
`include "sb_consts.svh"
`default_nettype none

module sb_issue_ctl (
    input  wire logic            REF_CLK_I,
    input  wire logic            NRST_I,
    input  wire sb_pkg::sb_ins_t FETCH0_I,
    input  wire sb_pkg::sb_ins_t FETCH1_I,
    input  wire logic            FETCH_VALID_I,
    input  wire logic            FETCH_QUAD_I,
    output var  logic            FETCH_READY_O,
    input  wire logic            ADDR_BUSY_I,
    input  wire logic            LOAD_MISS_I,
    input  wire logic [5:0]      MISS_REG_I,
    input  wire logic            FILL_NEAR_I,
    input  wire logic [5:0]      FILL_REG_I,
    input  wire logic            BARRIER_ACK_I,
    output var  sb_pkg::sb_ins_t ISSUE0_O,
    output var  sb_pkg::sb_ins_t ISSUE1_O,
    output var  logic            BARRIER_WAIT_O
);
    import sb_pkg::*;

    sb_st_t     q;
    sb_st_t     d;
    sb_ins_t    c0;
    sb_ins_t    c1;
    logic [1:0] ok;
    logic       iss0;
    logic       iss1;
    logic       pair_ok;
    logic       dep;
    logic       mul_busy;
    logic       div_busy;
    logic [5:0] mul_rem;
    logic [5:0] div_rem;
    logic       mul_go;
    logic       div_go;

    // True for the hard-wired zero register of either file.
    function automatic logic zr(input logic [5:0] r);
        zr = r[4:0] == `SB_ZERO_REG;
    endfunction

    // Classes that write their destination register.
    function automatic logic writer(input sb_cls_t c);
        writer = !(c inside {C_NONE, C_WRITE_INT, C_WRITE_FP, C_PREFILL,
                   C_MEM_BARRIER, C_TRAP_BARRIER, C_INT_COND_BRANCH,
                   C_FLOAT_COND_BRANCH, C_EXC_RETURN, C_HW_SPECIAL,
                   C_PRIV_CALL});
    endfunction

    // Classes whose second source is store data.
    function automatic logic is_store(input sb_cls_t c);
        is_store = c inside {C_WRITE_INT, C_WRITE_FP, C_STORE_COND};
    endfunction

    // Memory group allowed once per cycle.
    function automatic logic mem_grp(input sb_cls_t c);
        mem_grp = c inside {C_LOAD_INT, C_LOAD_FP, C_WRITE_INT, C_WRITE_FP,
                  C_STORE_COND, C_PROC_REG_MOVE, C_PREFILL, C_CYCLE_CTR,
                  C_FLAG_RDSET, C_MEM_BARRIER, C_TRAP_BARRIER,
                  C_BRANCH_SUB, C_UNCOND_JUMP, C_JUMP_SUB};
    endfunction

    // Memory group, linking jumps only when their link is live.
    function automatic logic held_cls(input sb_ins_t i);
        held_cls = mem_grp(i.cls) && !(zr(i.dst) && i.cls inside
                   {C_BRANCH_SUB, C_UNCOND_JUMP, C_JUMP_SUB});
    endfunction

    // Control transfers allowed once per cycle.
    function automatic logic ctl(input sb_cls_t c);
        ctl = c inside {C_JUMP_SUB, C_INT_COND_BRANCH, C_FLOAT_COND_BRANCH,
              C_BRANCH_SUB, C_UNCOND_JUMP, C_EXC_RETURN};
    endfunction

    // Stored wait: latency less one, so zero means readable now.
    function automatic logic [5:0] lat_st(input sb_cls_t c,
                                          input logic    dat);
        logic [5:0] l;
        case (c)
            C_INT_ADD_LOGIC: l = dat ? `SB_LAT_ADD_SD : `SB_LAT_ADD;
            C_SHIFT:         l = dat ? `SB_LAT_SHIFT_SD : `SB_LAT_SHIFT;
            C_INT_COMPARE,
            C_INT_COND_MOVE: l = `SB_LAT_CMP;
            C_INT_MULTIPLY:  l = 6'(`SB_LAT_MUL);
            C_FLOAT_OPERATE: l = `SB_LAT_FOP;
            C_FLOAT_DIVIDE:  l = 6'(`SB_LAT_DIV);
            C_LOAD_INT,
            C_LOAD_FP:       l = `SB_LAT_LOAD;
            default:         l = `SB_LAT_OTHER;
        endcase
        lat_st = (l == 6'h00) ? 6'h00 : l - 6'h01;
    endfunction

    // Source readiness against the base or store-data counter.
    function automatic logic rdy(input sb_st_t     s,
                                 input logic [5:0] r,
                                 input logic       dat);
        rdy = zr(r) || (!s.hold[r] &&
              (dat ? s.dcnt[r] == 6'h00 : s.cnt[r] == 6'h00));
    endfunction

    // True when an issued output carries the given class.
    function automatic logic has(input sb_ins_t a, input sb_cls_t c);
        has = a.vld && a.cls == c;
    endfunction

    assign c0 = q.slot[0];
    assign c1 = q.slot[1];

    // Multiplier and divider occupancy trackers.
    sb_unit_track #(
        .LAT (`SB_LAT_MUL),
        .OCC (`SB_OCC_MUL)
    ) u_mul (
        .clk_i    (REF_CLK_I),
        .nrst_i   (NRST_I),
        .start_i  (mul_go),
        .busy_o   (mul_busy),
        .remain_o (mul_rem)
    );

    sb_unit_track #(
        .LAT (`SB_LAT_DIV),
        .OCC (`SB_OCC_DIV)
    ) u_div (
        .clk_i    (REF_CLK_I),
        .nrst_i   (NRST_I),
        .start_i  (div_go),
        .busy_o   (div_busy),
        .remain_o (div_rem)
    );

    // Classes barred three cycles before a multiply ends.
    function automatic logic simple_int(input sb_cls_t c);
        simple_int = c inside {C_SHIFT, C_INT_ADD_LOGIC, C_INT_COMPARE,
                               C_INT_COND_MOVE};
    endfunction

    // Loads of either register file.
    function automatic logic is_load(input sb_cls_t c);
        is_load = c inside {C_LOAD_INT, C_LOAD_FP};
    endfunction

    // Conditional branches of either file.
    function automatic logic cond_br(input sb_cls_t c);
        cond_br = c inside {C_INT_COND_BRANCH, C_FLOAT_COND_BRANCH};
    endfunction

    // Computed jumps and returns; a conditional branch may not follow at once.
    function automatic logic jmp_cls(input sb_cls_t c);
        jmp_cls = c inside {C_JUMP_SUB, C_EXC_RETURN};
    endfunction

    // Classes allowed in the first place of a pair.
    function automatic logic first_cls(input sb_cls_t c);
        first_cls = c inside {C_LOAD_INT, C_LOAD_FP, C_WRITE_FP,
                    C_FLOAT_COND_BRANCH, C_INT_ADD_LOGIC, C_SHIFT,
                    C_INT_COMPARE, C_INT_COND_MOVE, C_INT_MULTIPLY};
    endfunction

    // Classes allowed in the second place of a pair.
    function automatic logic second_cls(input sb_cls_t c);
        second_cls = c inside {C_LOAD_FP, C_LOAD_INT, C_WRITE_INT,
                     C_INT_COND_BRANCH, C_FLOAT_OPERATE, C_FLOAT_DIVIDE,
                     C_JUMP_SUB, C_BRANCH_SUB, C_UNCOND_JUMP,
                     C_HW_SPECIAL, C_PRIV_CALL};
    endfunction

    // Destination clean: no miss outstanding and the own write lands last.
    function automatic logic dst_ok(input sb_st_t s, input sb_ins_t i);
        dst_ok = !writer(i.cls) || zr(i.dst) || (!s.hold[i.dst]
                 && (s.cnt[i.dst] == 6'h00
                     || s.cnt[i.dst] < lat_st(i.cls, 1'b0)));
    endfunction

    // Every single-slot hazard for one candidate.
    function automatic logic slot_ok(input sb_st_t     s,
                                     input sb_ins_t    i,
                                     input logic       abusy,
                                     input logic       mbusy,
                                     input logic       dbusy,
                                     input logic [5:0] mrem,
                                     input logic [5:0] drem);
        slot_ok = i.vld
            && (!i.sa_use || rdy(s, i.sa, 1'b0))
            && (!i.sb_use || rdy(s, i.sb, is_store(i.cls)))
            && dst_ok(s, i)
            && !(s.mb_pend && held_cls(i))
            && !(abusy && held_cls(i))
            && !(mbusy && i.cls == C_INT_MULTIPLY)
            && !(dbusy && i.cls == C_FLOAT_DIVIDE)
            && !(mrem == `SB_MUL_GAP && simple_int(i.cls))
            && !((drem == `SB_DIV_GAP_A || drem == `SB_DIV_GAP_B)
                 && i.cls == C_FLOAT_OPERATE)
            && !(s.jmp_prev && cond_br(i.cls))
            && !(s.sc_cnt != 2'd0 && is_load(i.cls));
    endfunction

    // Fetch handshake of this cycle.
    logic       take;

    // Hazards per slot, then pairing; the second never passes the first.
    always_comb begin
        take = q.ready && FETCH_VALID_I;
        for (int k = 0; k < 2; k++) begin
            ok[k] = slot_ok(q, q.slot[k], ADDR_BUSY_I, mul_busy, div_busy,
                            mul_rem, div_rem);
        end
        // Same-cycle use blocks a pair, except add result as store data.
        dep = writer(c0.cls) && !zr(c0.dst)
            && ((c1.sa_use && c1.sa == c0.dst)
                || (c1.sb_use && c1.sb == c0.dst
                    && !(c0.cls == C_INT_ADD_LOGIC && is_store(c1.cls)))
                || (writer(c1.cls) && c1.dst == c0.dst));
        pair_ok = q.quad && c0.vld && c1.vld
            && first_cls(c0.cls) && second_cls(c1.cls) && !dep
            && !(mem_grp(c0.cls) && mem_grp(c1.cls))
            && !(ctl(c0.cls) && ctl(c1.cls))
            && c1.cls != C_TRAP_BARRIER;
        iss0 = ok[0];
        iss1 = ok[1] && (!c0.vld || (iss0 && pair_ok));
        mul_go = (iss0 && c0.cls == C_INT_MULTIPLY)
              || (iss1 && c1.cls == C_INT_MULTIPLY);
        div_go = (iss0 && c0.cls == C_FLOAT_DIVIDE)
              || (iss1 && c1.cls == C_FLOAT_DIVIDE);
    end

    // Next state: scoreboard, miss holds, barrier, gaps and fetch slots.
    always_comb begin
        d = q;
        d.ack_sync = {q.ack_sync[0], BARRIER_ACK_I};
        for (int r = 0; r < `SB_NREG; r++) begin
            if (q.cnt[r] != 6'h00) begin
                d.cnt[r] = q.cnt[r] - 6'h01;
            end
            if (q.dcnt[r] != 6'h00) begin
                d.dcnt[r] = q.dcnt[r] - 6'h01;
            end
        end
        // A miss holds its register until the fill is near; set wins.
        if (FILL_NEAR_I) begin
            d.hold[FILL_REG_I] = 1'b0;
        end
        if (LOAD_MISS_I) begin
            d.hold[MISS_REG_I] = 1'b1;
        end
        // Issued producers arm their base and store-data counters.
        if (iss0 && writer(c0.cls) && !zr(c0.dst)) begin
            d.cnt[c0.dst]  = lat_st(c0.cls, 1'b0);
            d.dcnt[c0.dst] = lat_st(c0.cls, 1'b1);
        end
        if (iss1 && writer(c1.cls) && !zr(c1.dst)) begin
            d.cnt[c1.dst]  = lat_st(c1.cls, 1'b0);
            d.dcnt[c1.dst] = lat_st(c1.cls, 1'b1);
        end
        d.out0 = iss0 ? c0 : '0;
        d.out1 = iss1 ? c1 : '0;
        d.jmp_prev = (iss0 && jmp_cls(c0.cls))
                  || (iss1 && jmp_cls(c1.cls));
        if (has(d.out0, C_STORE_COND) || has(d.out1, C_STORE_COND)) begin
            d.sc_cnt = `SB_SC_GAP;
        end else if (q.sc_cnt != 2'd0) begin
            d.sc_cnt = q.sc_cnt - 2'd1;
        end
        // The synchronised acknowledge ends a barrier; a new one wins.
        if (q.ack_sync[1]) begin
            d.mb_pend = 1'b0;
        end
        if (has(d.out0, C_MEM_BARRIER) || has(d.out1, C_MEM_BARRIER)) begin
            d.mb_pend = 1'b1;
        end
        // A fetch pair is taken only into empty slots.
        if (take) begin
            d.slot[0] = FETCH0_I;
            d.slot[1] = FETCH1_I;
            d.quad    = FETCH_QUAD_I;
            d.ready   = 1'b0;
        end else begin
            if (iss0) begin
                d.slot[0].vld = 1'b0;
            end
            if (iss1) begin
                d.slot[1].vld = 1'b0;
            end
            d.ready = !(d.slot[0].vld || d.slot[1].vld);
        end
    end

    // State register.
    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register.
    assign FETCH_READY_O  = q.ready;
    assign ISSUE0_O       = q.out0;
    assign ISSUE1_O       = q.out1;
    assign BARRIER_WAIT_O = q.mb_pend;

    // Checks on the issue decisions and the issued stream.
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!NRST_I);

    chk_pair_order: assert property (
        (c0.vld && c1.vld && !iss0) |-> !iss1)
        else $error("second slot issued past a stalled first slot");
    chk_trap_second: assert property (
        (ISSUE0_O.vld && ISSUE1_O.vld) |-> ISSUE1_O.cls != C_TRAP_BARRIER)
        else $error("trap barrier issued second in a pair");
    chk_mem_once: assert property (
        (ISSUE0_O.vld && ISSUE1_O.vld)
            |-> !(mem_grp(ISSUE0_O.cls) && mem_grp(ISSUE1_O.cls)))
        else $error("two memory group instructions in one cycle");
    chk_load_gap: assert property (
        (has(ISSUE0_O, C_STORE_COND) || has(ISSUE1_O, C_STORE_COND))
            |=> (!(ISSUE0_O.vld && is_load(ISSUE0_O.cls))
                 && !(ISSUE1_O.vld && is_load(ISSUE1_O.cls)))[*2])
        else $error("load issued too soon after conditional store");
    chk_br_gap: assert property (
        ((ISSUE0_O.vld && jmp_cls(ISSUE0_O.cls))
         || (ISSUE1_O.vld && jmp_cls(ISSUE1_O.cls)))
            |=> !(ISSUE0_O.vld && cond_br(ISSUE0_O.cls))
                && !(ISSUE1_O.vld && cond_br(ISSUE1_O.cls)))
        else $error("conditional branch right after computed jump");
    chk_mul_free: assert property (
        mul_go |-> !mul_busy)
        else $error("multiply issued while multiplier busy");
    chk_div_free: assert property (
        div_go |-> !div_busy)
        else $error("divide issued while divider busy");
endmodule
`default_nettype wire

/* File: test/sb_unit_model.sv */
// Far-side model: address unit busy flags and barrier acknowledge.
// Assumes the issue controller's clock and its asynchronous reset.
`default_nettype none
module sb_unit_model #(
    parameter int ACK_DLY = 8
) (
    input  wire logic clk_i,
    input  wire logic nrst_i,
    input  wire logic barrier_wait_i,
    input  wire logic busy_req_i,
    output logic      barrier_ack_o,
    output logic      addr_busy_o,
    output logic      load_miss_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt;
    // Acknowledges a waiting barrier once the bus delay has passed.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt <= 0;
            barrier_ack_o <= 1'b0;
        end else begin
            cnt <= barrier_wait_i ? cnt + 1 : 0;
            barrier_ack_o <= barrier_wait_i && cnt >= ACK_DLY;
        end
    end
    // The unit is busy with a load miss whenever the bench asks for it.
    assign addr_busy_o = busy_req_i;
    assign load_miss_o = busy_req_i;
endmodule
`default_nettype wire

/* File: test/testbench.sv */
// Self-checking bench for the dual-issue issue controller.
// Assumes issued instructions show on ISSUE0_O and ISSUE1_O.
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
    $display("Error %s exp %0h got %0h", n, e, g); end end
module testbench;
    import sb_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        sb_ins_t a;
        sb_ins_t b;
        logic    q;
        logic    d;
    } sb_row_t;
    logic       clk = 1'b0;
    logic       nrst = 1'b0;
    sb_ins_t    f0 = '0;
    sb_ins_t    f1 = '0;
    sb_ins_t    i0, i1;
    logic       fv = 1'b0;
    logic       fq = 1'b0;
    logic       breq = 1'b0;
    logic       frdy, abusy, miss, ack, bwait;
    int         errors = 0;
    int         num_checks = 0;
    int         d;
    int         ti[$];
    sb_row_t    rows[8];

    sb_issue_ctl uut (
        .REF_CLK_I(clk), .NRST_I(nrst), .FETCH0_I(f0), .FETCH1_I(f1),
        .FETCH_VALID_I(fv), .FETCH_QUAD_I(fq), .FETCH_READY_O(frdy),
        .ADDR_BUSY_I(abusy), .LOAD_MISS_I(miss), .MISS_REG_I(6'h3e),
        .FILL_NEAR_I(1'b0), .FILL_REG_I(6'h3e), .BARRIER_ACK_I(ack),
        .ISSUE0_O(i0), .ISSUE1_O(i1), .BARRIER_WAIT_O(bwait)
    );
    sb_unit_model model (
        .clk_i(clk), .nrst_i(nrst), .barrier_wait_i(bwait),
        .busy_req_i(breq), .barrier_ack_o(ack), .addr_busy_o(abusy),
        .load_miss_o(miss)
    );

    // Makes the 25 MHz clock.
    always #20 clk = ~clk;
    // Logs the cycle of every issued instruction.
    always @(negedge clk) begin
        if (i0.vld === 1'b1) ti.push_back($time / 40);
        if (i1.vld === 1'b1) ti.push_back($time / 40);
    end

    function automatic sb_ins_t mk(sb_cls_t c, logic [5:0] w, r);
        mk = '{1'b1, c, w, r, 6'h1f, 1'b1, 1'b0};
    endfunction

    // Offers a fetch pair and holds it until the edge that takes it.
    task automatic send(sb_ins_t a, sb_ins_t b, logic q);
        int k = 0;
        @(negedge clk);
        f0 = a;
        f1 = b;
        fq = q;
        fv = 1'b1;
        #1;
        while (frdy !== 1'b1 && k < 100) begin
            @(negedge clk);
            k++;
        end
        `CHK("ready", 1'b1, frdy)
        @(negedge clk);
        fv = 1'b0;
    endtask

    // Runs two instructions and measures the gap between their issues.
    task automatic run(sb_ins_t a, sb_ins_t b, logic q, logic sep);
        ti.delete();
        if (sep) begin
            send(a, '0, 1'b0);
            send(b, '0, 1'b0);
        end else send(a, b, q);
        repeat (80) @(negedge clk);
        d = (ti.size() == 2) ? ti[1] - ti[0] : -1;
    endtask

    task automatic seq(sb_ins_t a, sb_ins_t b);
        run(a, b, 1'b0, 1'b1);
    endtask

    task automatic report_and_stop();
        if (errors == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Cuts a hang short.
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        report_and_stop();
    end

    // Main sequence: reset, pairing table, then timing cases.
    initial begin
        rows[0] = '{mk(C_LOAD_INT, 1, 10), mk(C_LOAD_FP, 33, 11), 1'b1, 1'b0};
        rows[1] = '{mk(C_LOAD_INT, 1, 10), mk(C_LOAD_FP, 33, 11), 1'b0, 1'b0};
        rows[2] = '{mk(C_INT_ADD_LOGIC, 2, 12), mk(C_FLOAT_OPERATE, 34, 40),
                    1'b1, 1'b1};
        rows[3] = '{mk(C_INT_ADD_LOGIC, 3, 12), mk(C_TRAP_BARRIER, 31, 31),
                    1'b1, 1'b0};
        rows[4] = '{mk(C_LOAD_INT, 4, 10), mk(C_WRITE_INT, 31, 13), 1'b1, 1'b0};
        rows[5] = '{mk(C_SHIFT, 6, 12), mk(C_JUMP_SUB, 5, 6), 1'b1, 1'b0};
        rows[6] = '{mk(C_INT_COMPARE, 7, 12), mk(C_JUMP_SUB, 26, 13),
                    1'b1, 1'b1};
        rows[7] = '{mk(C_INT_ADD_LOGIC, 2, 12),
                    '{1'b1, C_WRITE_INT, 6'h1f, 6'h0a, 6'h02, 1'b1, 1'b1},
                    1'b1, 1'b1};
        repeat (16) @(negedge clk);
        nrst = 1'b1;
        `CHK("issue0", 1'b0, i0.vld)
        `CHK("bwait", 1'b0, bwait)
        foreach (rows[n]) begin
            run(rows[n].a, rows[n].b, rows[n].q, 1'b0);
            `CHK("dual", rows[n].d, d == 0)
            `CHK("count", 2, ti.size())
        end
        seq(mk(C_STORE_COND, 31, 14), mk(C_LOAD_INT, 8, 15));
        `CHK("sc_gap", 1'b1, d >= 3)
        seq(mk(C_LOAD_INT, 9, 10), mk(C_INT_ADD_LOGIC, 16, 9));
        `CHK("ld_use", 1'b1, d >= 3)
        seq(mk(C_INT_MULTIPLY, 17, 10), mk(C_INT_MULTIPLY, 18, 11));
        `CHK("mul_occ", 1'b1, d >= 19)
        seq(mk(C_INT_MULTIPLY, 19, 10), mk(C_INT_MULTIPLY, 20, 19));
        `CHK("mul_dep", 1'b1, d >= 21)
        // No store here takes a divide result as its base.
        seq(mk(C_FLOAT_DIVIDE, 35, 36), mk(C_FLOAT_DIVIDE, 37, 38));
        `CHK("div_occ", 1'b1, d >= 30)
        seq(mk(C_JUMP_SUB, 21, 10), mk(C_INT_COND_BRANCH, 31, 11));
        `CHK("jmp_br", 1'b1, d >= 2)
        seq(mk(C_MEM_BARRIER, 31, 31), mk(C_LOAD_INT, 22, 10));
        `CHK("mb_gap", 1'b1, d >= 8)
        breq = 1'b1;
        ti.delete();
        send(mk(C_LOAD_INT, 23, 10), '0, 1'b0);
        repeat (20) @(negedge clk);
        `CHK("abusy", 1'b1, ti.size() == 0)
        breq = 1'b0;
        repeat (20) @(negedge clk);
        `CHK("abusy_end", 1'b1, ti.size() == 1)
        // Reset in mid-run while a barrier is still waiting.
        send(mk(C_MEM_BARRIER, 31, 31), '0, 1'b0);
        repeat (2) @(negedge clk);
        `CHK("bwait_set", 1'b1, bwait)
        nrst = 1'b0;
        #1;
        `CHK("bwait_rst", 1'b0, bwait)
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        `CHK("issue_rst", 1'b0, i0.vld)
        report_and_stop();
    end
endmodule
`default_nettype wire
